// ---- hw/src_reset_controller.sv ----
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
module src_reset_controller
  import src_pkg::*;
#(
  parameter int EXT_FILTER_CYC = 16,
  parameter int SUT_UNIT_CYC   = 100000
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        brownout_low,
  input  wire logic        brownout_fuse_config,
  input  wire logic        reset_pin_n,
  input  wire logic        reset_pin_function_fuse,
  input  wire logic        watchdog_timer_req,
  input  wire logic        program_debug_port_req,
  input  wire logic [2:0]  startup_delay_setting,
  input  wire logic        boot_scan_source,
  input  wire logic        memory_scan_done,
  output logic             sys_reset_n,
  output logic             debug_reset_n,
  output logic             fuse_load,
  output logic             memory_scan_start
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic        bod_in;
  logic        pin_low;
  logic        dbg_in;

  // Power-on reset is the async resetn itself, so it acts with no clock at all
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {brownout_low, ~reset_pin_n, program_debug_port_req};
      sync2_ff <= sync1_ff;
    end
  end
  assign bod_in  = sync2_ff[2];
  assign pin_low = sync2_ff[1];
  assign dbg_in  = sync2_ff[0];

  // ****************************************
  // Source qualification
  // ****************************************
  logic [15:0] ext_cnt_ff;
  logic        ext_act_ff;
  logic        bod_act;
  logic        wdt_act;

  assign bod_act = bod_in && brownout_fuse_config;
  assign wdt_act = watchdog_timer_req;

  // Glitch filter: a short low never reaches the sequencer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_cnt_ff <= 16'h0000;
      ext_act_ff <= 1'b0;
    end else if (!pin_low || !reset_pin_function_fuse) begin
      ext_cnt_ff <= 16'h0000;
      ext_act_ff <= 1'b0;
    end else if (ext_cnt_ff == 16'(EXT_FILTER_CYC - 1)) begin
      ext_act_ff <= 1'b1;
    end else begin
      ext_cnt_ff <= ext_cnt_ff + 16'h0001;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic        aw_ok_ff;
  logic [5:0]  awaddr_ff;
  logic        w_ok_ff;
  logic [7:0]  wdata_ff;
  logic        wlane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        do_wr;
  logic        wr_cause;
  logic        wr_soft_reset_trigger;
  logic        wr_unlock;
  logic [2:0]  unlock_ff;
  logic        sw_req;
  logic [5:0]  cause_ff;

  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  assign do_wr     = aw_ok_ff && w_ok_ff;
  assign wr_cause  = do_wr && wlane_ff && (awaddr_ff == ADDR_CAUSE);
  assign wr_soft_reset_trigger  = do_wr && wlane_ff && (awaddr_ff == ADDR_SOFT_RESET_TRIGGER);
  assign wr_unlock = do_wr && wlane_ff && (awaddr_ff == ADDR_UNLOCK);
  // Locked writes are accepted with OKAY but change nothing
  assign sw_req    = wr_soft_reset_trigger && wdata_ff[BIT_SOFT_TRIG] && (unlock_ff != 3'h0);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_ok_ff  <= 1'b0;
      awaddr_ff <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_ff  <= 1'b1;
      awaddr_ff <= {s_axi_awaddr[5:2], 2'b00};
    end else if (do_wr) begin
      aw_ok_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      w_ok_ff  <= 1'b0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ok_ff  <= 1'b1;
      wdata_ff <= s_axi_wdata[7:0];
      wlane_ff <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_ok_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awaddr_ff[5:2] > IDX_UNLOCK) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      case (s_axi_araddr[5:2])
        IDX_CAUSE:  rdata_ff <= {26'h0, cause_ff};
        IDX_SOFT_RESET_TRIGGER:  rdata_ff <= 32'h0000_0000;
        IDX_UNLOCK: rdata_ff <= {31'h0, unlock_ff != 3'h0};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // One instruction per clock is assumed, so the window closes after four cycles
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unlock_ff <= 3'h0;
    end else if (wr_unlock && wdata_ff == UNLOCK_KEY) begin
      unlock_ff <= UNLOCK_WINDOW;
    end else if (unlock_ff != 3'h0) begin
      unlock_ff <= unlock_ff - 3'h1;
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  src_state_t       state_ff;
  src_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             psu_ff;
  logic             level_req;
  logic             pulse_req;
  logic [CNT_W-1:0] sut_cyc;

  assign level_req = bod_act || ext_act_ff || dbg_in;
  assign pulse_req = wdt_act || sw_req;
  assign sut_cyc   = CNT_W'(startup_delay_setting) * CNT_W'(SUT_UNIT_CYC);

  // Level sources win over everything; a pulse restarts the sequence from the top
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff == '0) ? '0 : cnt_ff - CNT_W'(1);
    if (level_req) begin
      nxt_state = ST_HOLD;
    end else if (pulse_req) begin
      nxt_state = ST_PULSE;
      nxt_cnt   = CNT_W'(PULSE_CYC - 1);
    end else begin
      case (state_ff)
        ST_RUN:  nxt_state = ST_RUN;
        ST_HOLD: begin
          nxt_state = ST_FUSE;
          nxt_cnt   = CNT_W'(FUSE_LOAD_CYC - 1);
        end
        ST_PULSE: begin
          if (cnt_ff == '0) begin
            nxt_state = ST_FUSE;
            nxt_cnt   = CNT_W'(FUSE_LOAD_CYC - 1);
          end
        end
        ST_FUSE: begin
          if (cnt_ff == '0) begin
            if (psu_ff && sut_cyc != '0) begin
              nxt_state = ST_SUT;
              nxt_cnt   = sut_cyc - CNT_W'(1);
            end else if (boot_scan_source) begin
              nxt_state = ST_SCAN;
            end else begin
              nxt_state = ST_RUN;
            end
          end
        end
        ST_SUT: begin
          if (cnt_ff == '0) begin
            nxt_state = boot_scan_source ? ST_SCAN : ST_RUN;
          end
        end
        ST_SCAN: begin
          if (memory_scan_done && !memory_scan_start) begin
            nxt_state = ST_RUN;
          end
        end
        default: nxt_state = ST_HOLD;
      endcase
    end
  end

  // Free-running clock, never gated by sleep, so sources are seen in any mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      psu_ff <= 1'b1;
    end else if (bod_act) begin
      psu_ff <= 1'b1;
    end else if (state_ff == ST_RUN) begin
      psu_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_reset_n       <= 1'b0;
      fuse_load         <= 1'b0;
      memory_scan_start <= 1'b0;
      debug_reset_n     <= 1'b0;
    end else begin
      sys_reset_n       <= (nxt_state == ST_RUN);
      fuse_load         <= (nxt_state == ST_FUSE);
      memory_scan_start <= (nxt_state == ST_SCAN) && (state_ff != ST_SCAN);
      debug_reset_n     <= 1'b1;
    end
  end

  // ****************************************
  // Cause flags
  // ****************************************
  logic [5:0] set_vec;
  logic [5:0] clr_vec;

  assign set_vec = {dbg_in, sw_req, wdt_act, ext_act_ff, 2'b00};
  assign clr_vec = wr_cause ? wdata_ff[5:0] : 6'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cause_ff <= CAUSE_RESET;
    end else if (bod_act) begin
      cause_ff <= (cause_ff & CAUSE_BOR_KEEP) | (6'h01 << BIT_BOR);
    end else begin
      cause_ff <= (cause_ff & ~clr_vec) | set_vec;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_sw_write;
    wr_soft_reset_trigger && wdata_ff[BIT_SOFT_TRIG];
  endsequence

  sequence s_reset_low2;
    !sys_reset_n ##1 !sys_reset_n;
  endsequence

  sequence s_pulse_done;
    state_ff == ST_PULSE && cnt_ff == '0 && !level_req && !pulse_req;
  endsequence

  a_sw_locked: assert property (s_sw_write and (unlock_ff == 3'h0)
                                and (state_ff == ST_RUN) and (!level_req && !wdt_act)
                                |=> sys_reset_n)
    else $error("software reset taken without unlock");
  a_sw_starts: assert property (s_sw_write and (unlock_ff != 3'h0) |=> s_reset_low2)
    else $error("software reset did not assert reset");
  a_pulse_len: assert property ($rose(state_ff == ST_PULSE)
                                |-> cnt_ff == CNT_W'(PULSE_CYC - 1))
    else $error("reset pulse length wrong");
  a_pulse_fuse: assert property (s_pulse_done |=> state_ff == ST_FUSE && fuse_load)
    else $error("fuse reload did not follow the reset pulse");
  a_soft_reset_trigger_reads: assert property (s_axi_arvalid && s_axi_arready
                                  && s_axi_araddr[5:2] == IDX_SOFT_RESET_TRIGGER
                                  |=> s_axi_rdata == 32'h0)
    else $error("software reset bit read nonzero");
  a_bod_flags: assert property (bod_act |=> cause_ff[BIT_BOR] && cause_ff[5:2] == 4'h0)
    else $error("brown-out flag handling wrong");
  a_pin_hold: assert property (ext_act_ff |=> !sys_reset_n)
    else $error("pin reset did not hold reset");
  a_sut_psu: assert property (state_ff == ST_SUT |-> psu_ff)
    else $error("start-up delay on a user reset");
  a_debug_keep: assert property (debug_reset_n |=> debug_reset_n)
    else $error("debug port reset by a non power-on reset");
  a_flag_set: assert property (ext_act_ff && !bod_act |=> cause_ff[BIT_PIN])
    else $error("pin flag not set");
  a_filter_min: assert property ($rose(ext_act_ff)
                                 |-> $past(ext_cnt_ff) == 16'(EXT_FILTER_CYC - 1))
    else $error("pin reset without a long enough low input");
  a_init_done: assert property ($rose(sys_reset_n)
                                |-> $past(state_ff) != ST_HOLD && $past(state_ff) != ST_PULSE)
    else $error("reset released before initialization finished");
  a_level_hold: assert property (level_req |=> !sys_reset_n)
    else $error("level reset source did not hold reset");
  a_user_no_sut: assert property (state_ff == ST_FUSE && cnt_ff == '0 && !psu_ff
                                  && !level_req && !pulse_req |=> state_ff != ST_SUT)
    else $error("start-up delay added after a user reset");
  a_scan_wait: assert property (state_ff == ST_SCAN && !memory_scan_done
                                && !level_req && !pulse_req |=> state_ff == ST_SCAN)
    else $error("scan wait left before the scan finished");
  a_flag_clear: assert property (wr_cause && !bod_act
                                 |=> (cause_ff & $past(clr_vec) & ~$past(set_vec)) == 6'h00)
    else $error("cause flag not cleared by a one");
  a_dbg_flag: assert property (dbg_in && !bod_act |=> cause_ff[BIT_DBG])
    else $error("debug flag not set");

endmodule : src_reset_controller

// ---- shared/src_pkg.sv ----
// Operation
// - Optional sources request reset only when their fuse or software enable is set.
// - Every reset reloads all fuse-backed registers before the system runs.
// - Each reset records its cause in the cause flag register.
// - Power-on reset is always on; reset holds until initialization completes.
// - Power-on detection reasserts reset at once, with no delay.
// - Enabled brown-out holds reset until supply rises above threshold.
// - Reset pin is filtered; only a long enough low level requests reset.
// - Enabled reset pin holds reset while low, releases when high again.
// - Watchdog timeout request issues a watchdog reset.
// - Watchdog and software resets give an internal pulse of about 150 ns.
// - Writing one to bit 0 of the software reset register starts reset.
// - The software reset bit always reads as zero.
// - Software reset write counts only within four instructions after unlock key.
// - All resets reload fuses; only power-on also resets debug-port logic.
// - Start-up delay lengthens initialization only after power-on or brown-out.
// - Enabled start-up memory scan further lengthens initialization.
// - The controller runs in active mode and every sleep mode.
// - Writing one clears a cause flag; writing zero leaves it.
// - Power-on reset clears all cause flags and sets the power-on flag.
// - Brown-out reset clears all flags except power-on and brown-out.
// - Flags: debug bit 5, software 4, watchdog 3, pin 2, brown-out 1, power-on 0.
package src_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] IDX_CAUSE  = 4'h0;
  localparam logic [3:0] IDX_SOFT_RESET_TRIGGER  = 4'h1;
  localparam logic [3:0] IDX_UNLOCK = 4'h2;
  localparam logic [5:0] ADDR_CAUSE  = {IDX_CAUSE, 2'b00};
  localparam logic [5:0] ADDR_SOFT_RESET_TRIGGER  = {IDX_SOFT_RESET_TRIGGER, 2'b00};
  localparam logic [5:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'b00};

  localparam int BIT_POR = 0;
  localparam int BIT_BOR = 1;
  localparam int BIT_PIN = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_SW  = 4;
  localparam int BIT_DBG = 5;
  localparam int BIT_SOFT_TRIG = 0;

  localparam logic [5:0] CAUSE_RESET = 6'h01;
  localparam logic [5:0] CAUSE_BOR_KEEP = 6'h03;
  // Arbitrary unlock key value
  localparam logic [7:0] UNLOCK_KEY = 8'h5a;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int PULSE_NS = 150;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int FUSE_LOAD_CYC = 8;
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_HOLD  = 3'b001,
    ST_PULSE = 3'b010,
    ST_FUSE  = 3'b011,
    ST_SUT   = 3'b100,
    ST_SCAN  = 3'b101
  } src_state_t;

endpackage : src_pkg

// ---- verification/src_reset_controller_test.sv ----
`timescale 1ns/10ps
module src_reset_controller_test
  import src_pkg::*;
;
  localparam int FILT = 4;
  localparam int STARTUP_DELAY_SETTING  = 10;
  localparam int SUTSET = 2;
  logic        clock, resetn, awvalid, wvalid, arvalid, awready, wready, arready;
  logic [5:0]  awaddr, araddr, f;
  logic [31:0] wdata, rdata, rng;
  logic [1:0]  bresp, rresp;
  logic        bvalid, rvalid, bready, rready, bod_low, bod_en, pin_n, pin_en;
  logic        wdt_req, dbg_req, scan_en, scan_done, sys_n, dbg_n, fuse_ld, scan_st;
  logic [7:0]  m;
  logic [2:0]  sut_set;
  logic [33:0] exp_q[$];
  int          mismatches = 0, cmp_count = 0, low_cnt = 0, fuse_cnt = 0, scan_cnt = 0, t;

  src_reset_controller #(.EXT_FILTER_CYC(FILT), .SUT_UNIT_CYC(STARTUP_DELAY_SETTING)) dut_u (
    .clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brownout_low(bod_low), .brownout_fuse_config(bod_en), .reset_pin_n(pin_n),
    .reset_pin_function_fuse(pin_en), .watchdog_timer_req(wdt_req),
    .program_debug_port_req(dbg_req), .startup_delay_setting(sut_set),
    .boot_scan_source(scan_en), .memory_scan_done(scan_done), .sys_reset_n(sys_n),
    .debug_reset_n(dbg_n), .fuse_load(fuse_ld), .memory_scan_start(scan_st));

  src_source_model model_u (
    .clock(clock), .memory_scan_start(scan_st), .brownout_low(bod_low),
    .reset_pin_n(pin_n), .watchdog_timer_req(wdt_req),
    .program_debug_port_req(dbg_req), .memory_scan_done(scan_done));

  // ****************************************
  // Helpers
  // ****************************************
  always #5 clock = ~clock;

  always @(posedge clock) begin
    low_cnt <= low_cnt + int'(!sys_n);
    fuse_cnt <= fuse_cnt + int'(fuse_ld);
    scan_cnt <= scan_cnt + int'(scan_st);
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  always @(posedge clock) begin
    if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // One access at a time; the expected answer is queued before it is issued
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [1:0] r);
    exp_q.push_back({r, 24'h0, w ? 8'h00 : d});
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    // Only the watchdog process ends a wait that never gets its answer
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid));
  endtask : bus

  task automatic wait_run();
    while (sys_n !== 1'b1) @(posedge clock);
  endtask : wait_run

  task automatic report_and_stop();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {awvalid, wvalid, arvalid, scan_en} = 4'h0;
    {bready, rready, bod_en, pin_en} = 4'hf;
    {awaddr, araddr, wdata} = '0;
    rng = 32'h07fe9c45;
    sut_set = 3'(SUTSET);
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    wait_run();
    check(34'(low_cnt >= FUSE_LOAD_CYC + SUTSET * STARTUP_DELAY_SETTING), 34'h1);
    check(34'(fuse_cnt), 34'(FUSE_LOAD_CYC));
    check(34'(dbg_n), 34'h1);
    bus(1'b0, ADDR_CAUSE, 8'h01, RESP_OKAY);
    bus(1'b1, ADDR_CAUSE, 8'h00, RESP_OKAY);
    bus(1'b0, ADDR_CAUSE, 8'h01, RESP_OKAY);
    bus(1'b1, ADDR_CAUSE, 8'h01, RESP_OKAY);
    bus(1'b1, ADDR_SOFT_RESET_TRIGGER, 8'h01, RESP_OKAY);
    bus(1'b0, ADDR_SOFT_RESET_TRIGGER, 8'h00, RESP_OKAY);
    check(34'(sys_n), 34'h1);
    bus(1'b1, ADDR_UNLOCK, UNLOCK_KEY, RESP_OKAY);
    t = low_cnt;
    bus(1'b1, ADDR_SOFT_RESET_TRIGGER, 8'h01, RESP_OKAY);
    #1;
    check(34'(sys_n), 34'h0);
    wait_run();
    check(34'(low_cnt - t >= PULSE_CYC + FUSE_LOAD_CYC), 34'h1);
    check(34'(low_cnt - t < PULSE_CYC + FUSE_LOAD_CYC + SUTSET * STARTUP_DELAY_SETTING), 34'h1);
    bus(1'b0, ADDR_CAUSE, 8'h10, RESP_OKAY);
    model_u.drive_src(3, 1);
    repeat (2) @(posedge clock);
    check(34'(sys_n), 34'h0);
    wait_run();
    bus(1'b0, ADDR_CAUSE, 8'h18, RESP_OKAY);
    // Slow scan on a debugger reset: release must wait for the scan
    scan_en <= 1'b1;
    model_u.scan_lat = 30;
    t = low_cnt;
    f = 6'(scan_cnt);
    model_u.drive_src(2, 5);
    wait_run();
    check(34'(scan_cnt - int'(f)), 34'h1);
    check(34'(low_cnt - t >= FUSE_LOAD_CYC + 30), 34'h1);
    check(34'(dbg_n), 34'h1);
    scan_en <= 1'b0;
    bus(1'b0, ADDR_CAUSE, 8'h38, RESP_OKAY);
    t = low_cnt;
    model_u.drive_src(0, FILT - 1);
    repeat (8) @(posedge clock);
    check(34'(low_cnt - t), 34'h0);
    pin_en <= 1'b0;
    model_u.drive_src(0, 20);
    // Let the synchronised pin go high before the enable returns
    repeat (4) @(posedge clock);
    check(34'(low_cnt - t), 34'h0);
    pin_en <= 1'b1;
    model_u.drive_src(0, 30);
    check(34'(sys_n), 34'h0);
    wait_run();
    bus(1'b0, ADDR_CAUSE, 8'h3c, RESP_OKAY);
    f = 6'h3c;
    repeat (4) begin
      rng = xs(rng);
      m = rng[7:0];
      f = f & ~m[5:0];
      bus(1'b1, ADDR_CAUSE, m, RESP_OKAY);
      bus(1'b0, ADDR_CAUSE, {2'b00, f}, RESP_OKAY);
    end
    bod_en <= 1'b0;
    t = low_cnt;
    model_u.drive_src(1, 20);
    repeat (4) @(posedge clock);
    check(34'(low_cnt - t), 34'h0);
    bod_en <= 1'b1;
    t = low_cnt;
    model_u.drive_src(1, 20);
    check(34'(sys_n), 34'h0);
    wait_run();
    check(34'(low_cnt - t >= FUSE_LOAD_CYC + SUTSET * STARTUP_DELAY_SETTING), 34'h1);
    bus(1'b0, ADDR_CAUSE, {6'h00, 1'b1, f[0]}, RESP_OKAY);
    bus(1'b0, 6'h0c, 8'h00, RESP_SLVERR);
    sut_set <= 3'h0;
    resetn <= 1'b0;
    #1;
    check(34'({sys_n, dbg_n}), 34'h0);
    repeat (3) @(posedge clock);
    t = low_cnt;
    resetn <= 1'b1;
    wait_run();
    check(34'(low_cnt - t < FUSE_LOAD_CYC + SUTSET * STARTUP_DELAY_SETTING), 34'h1);
    bus(1'b0, ADDR_CAUSE, 8'h01, RESP_OKAY);
    @(posedge clock);
    report_and_stop();
  end

  initial begin
    #300us;
    mismatches++;
    report_and_stop();
  end
endmodule : src_reset_controller_test

// ---- verification/src_source_model.sv ----
`timescale 1ns/10ps
module src_source_model (
  input  wire logic clock,
  input  wire logic memory_scan_start,
  output logic      brownout_low,
  output logic      reset_pin_n,
  output logic      watchdog_timer_req,
  output logic      program_debug_port_req,
  output logic      memory_scan_done
);
  int scan_lat = 3;
  int scan_cnt = 0;
  initial begin
    brownout_low = 1'b0;
    reset_pin_n = 1'b1;
    watchdog_timer_req = 1'b0;
    program_debug_port_req = 1'b0;
    memory_scan_done = 1'b0;
  end
  // Called right after an edge; pin released goes to its pull-up level
  task automatic drive_src(input int which, input int n);
    case (which)
      0: reset_pin_n <= 1'b0;
      1: brownout_low <= 1'b1;
      2: program_debug_port_req <= 1'b1;
      default: watchdog_timer_req <= 1'b1;
    endcase
    repeat (n) @(posedge clock);
    reset_pin_n <= 1'b1;
    brownout_low <= 1'b0;
    program_debug_port_req <= 1'b0;
    watchdog_timer_req <= 1'b0;
  endtask : drive_src
  // Scan answers after a settable latency so slow memories can be mimicked
  always @(posedge clock) begin
    if (memory_scan_start) begin
      memory_scan_done <= 1'b0;
      scan_cnt <= scan_lat;
    end else if (scan_cnt > 0) begin
      scan_cnt <= scan_cnt - 1;
      if (scan_cnt == 1) memory_scan_done <= 1'b1;
    end
  end
endmodule : src_source_model
